// ### rtc_i2c_slave_bus_recovery_tb.sv
// self-checking bench for the clock chip serial slave
`timescale 1ns/1ps
`include "rtcs_defs.svh"
module rtc_i2c_slave_bus_recovery_tb;
    import rtcs_pkg::*;
    localparam logic [7:0] AW = {`RTCS_DEV_ADDR, 1'b0};
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic bus_rst_n_in = 1'b1;
    logic tick_in = 1'b0;
    logic scl;
    logic sda_low;
    logic sda_oe;
    logic frozen;
    wire logic sda;
    rtcs_byte_t sec_bcd;
    rtcs_byte_t min_bcd;
    rtcs_byte_t hour_bcd;
    int n_mismatch = 0;
    int compares = 0;
    logic a;
    logic [7:0] d;
    // open drain wire with pull-up
    assign sda = ~(sda_low | sda_oe);
    always #20 clock = ~clock;
    rtcs_master_model m (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
    rtcs_slave uut (
        .clock(clock), .srst(srst), .scl_in(scl), .sda_in(sda),
        .bus_rst_n_in(bus_rst_n_in), .tick_in(tick_in), .sda_oe(sda_oe),
        .sec_bcd(sec_bcd), .min_bcd(min_bcd), .hour_bcd(hour_bcd), .frozen(frozen)
    );
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic test_done();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic tick();
        @(negedge clock);
        tick_in = 1'b1;
        repeat (6) @(negedge clock);
        tick_in = 1'b0;
        repeat (6) @(negedge clock);
    endtask
    task automatic wait_sec(input logic [7:0] exp);
        int i;
        for (i = 0; i < 40 && sec_bcd !== exp; i++) @(negedge clock);
        chk("sec_bcd", exp, sec_bcd);
        if (i == 40) test_done();
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [23:0] dat, input int n);
        m.start();
        m.wbyte(AW, a);
        chk("addr ack", 8'h01, {7'h00, a});
        m.wbyte(ptr, a);
        chk("ptr ack", 8'h01, {7'h00, a});
        for (int i = 0; i < n; i++) begin
            m.wbyte(dat[23-8*i -: 8], a);
            chk("data ack", 8'h01, {7'h00, a});
        end
        m.stop();
    endtask
    task automatic rd(input logic [7:0] ptr, input logic [23:0] exp, input int n);
        m.start();
        m.wbyte(AW, a);
        m.wbyte(ptr, a);
        m.start();
        m.wbyte(AW | 8'h01, a);
        chk("read addr ack", 8'h01, {7'h00, a});
        for (int i = 0; i < n; i++) begin
            m.rbyte(i < n - 1, d);
            chk("read data", exp[23-8*i -: 8], d);
        end
        m.stop();
    endtask
    // wrap of all three counters at the top of the day
    task automatic t_write_read();
        wr(8'h00, 24'h58_5923, 3);
        chk("sec_bcd", 8'h58, sec_bcd);
        chk("min_bcd", 8'h59, min_bcd);
        chk("hour_bcd", 8'h23, hour_bcd);
        rd(8'h00, 24'h58_5923, 3);
        tick();
        wait_sec(8'h59);
        tick();
        wait_sec(8'h00);
        repeat (2) @(negedge clock);
        chk("min_bcd", 8'h00, min_bcd);
        chk("hour_bcd", 8'h00, hour_bcd);
    endtask
    task automatic t_range();
        wr(8'h00, 24'h61_0000, 1);
        chk("sec_bcd", 8'h61, sec_bcd);
        tick();
        wait_sec(8'h00);
        repeat (2) @(negedge clock);
        chk("min_bcd", 8'h01, min_bcd);
    endtask
    task automatic t_gencall();
        m.start();
        m.wbyte(8'h00, a);
        chk("general call ack", 8'h00, {7'h00, a});
        m.wbyte(8'h5A, a);
        chk("general call data ack", 8'h00, {7'h00, a});
        m.stop();
    endtask
    task automatic t_freeze();
        m.start();
        m.wbyte(AW, a);
        tick();
        chk("frozen", 8'h01, {7'h00, frozen});
        chk("sec_bcd", 8'h00, sec_bcd);
        m.stop();
        wait_sec(8'h01);
    endtask
    // two ticks inside one open transfer: abort, one second lost
    task automatic t_abort();
        m.start();
        m.wbyte(AW, a);
        tick();
        tick();
        wait_sec(8'h02);
        chk("frozen", 8'h00, {7'h00, frozen});
        chk("sda_oe", 8'h00, {7'h00, sda_oe});
        repeat (20) @(negedge clock);
        chk("sec_bcd", 8'h02, sec_bcd);
        m.stop();
    endtask
    // bus reset lands while the slave still holds its ack
    task automatic t_busrst();
        m.start();
        m.wbyte(AW, a);
        m.wbyte(8'h01, a);
        bus_rst_n_in = 1'b0;
        repeat (4) @(negedge clock);
        bus_rst_n_in = 1'b1;
        repeat (2) @(negedge clock);
        chk("frozen", 8'h00, {7'h00, frozen});
        chk("sda_oe", 8'h00, {7'h00, sda_oe});
        chk("sec_bcd", 8'h02, sec_bcd);
        chk("min_bcd", 8'h01, min_bcd);
        m.stop();
    endtask
    // master walks away from a read, slave keeps data low
    task automatic t_recover();
        m.start();
        m.wbyte(AW | 8'h01, a);
        repeat (6) @(negedge clock);
        chk("sda stuck", 8'h00, {7'h00, sda});
        m.pulses9();
        repeat (6) @(negedge clock);
        chk("sda_oe", 8'h00, {7'h00, sda_oe});
        m.stop();
        repeat (4) @(negedge clock);
        chk("frozen", 8'h00, {7'h00, frozen});
        wr(8'h00, 24'h30_0000, 1);
        chk("sec_bcd", 8'h30, sec_bcd);
    endtask
    // another device holds data low: nine clocks must free the slave before any stop
    task automatic t_stuck();
        m.start();
        repeat (9) m.bit_io(1'b0, a);
        repeat (6) @(negedge clock);
        chk("frozen", 8'h00, {7'h00, frozen});
        chk("sda_oe", 8'h00, {7'h00, sda_oe});
        m.stop();
        wr(8'h01, 24'h45_0000, 1);
        chk("min_bcd", 8'h45, min_bcd);
    endtask
    initial begin
        repeat (6) @(negedge clock);
        srst = 1'b0;
        repeat (4) @(negedge clock);
        t_write_read();
        t_range();
        t_gencall();
        t_freeze();
        t_abort();
        t_busrst();
        t_recover();
        t_stuck();
        test_done();
    end
    initial begin
        repeat (100000) @(posedge clock);
        n_mismatch++;
        test_done();
    end
endmodule

// ### rtcs_bcd_cnt.sv
// one bcd time counter with raw load and self-healing wrap
`timescale 1ns/1ps
`include "rtcs_defs.svh"
module rtcs_bcd_cnt #(
    parameter logic [7:0] MAX_VAL = `RTCS_SEC_MAX
) (
    input wire logic clock,
    input wire logic srst,
    rtcs_cnt_if.cnt c
);
    import rtcs_pkg::*;
    rtcs_byte_t val_r;
    rtcs_byte_t val_nxt;
    logic wrap;

    always_comb begin
        wrap = (val_r >= MAX_VAL);
        val_nxt = val_r;
        if (c.wr) begin
            val_nxt = c.wdata; // no range check on load
        end else if (c.inc) begin
            if (wrap) begin
                val_nxt = `RTCS_VAL_RST; // any out-of-range value heals here
            end else if (val_r[3:0] >= `RTCS_BCD_DIGIT_MAX) begin
                val_nxt = {val_r[7:4] + 4'h1, 4'h0}; // bcd digit carry
            end else begin
                val_nxt = val_r + 8'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            val_r <= `RTCS_VAL_RST;
        end else begin
            val_r <= val_nxt;
        end
    end

    assign c.value = val_r;
    assign c.carry = c.inc && !c.wr && wrap;

    chk_raw_store: assert property (@(posedge clock) disable iff (srst)
        c.wr |=> val_r == $past(c.wdata)) else $error("written value not stored");
    chk_wrap_valid: assert property (@(posedge clock) disable iff (srst)
        c.inc && !c.wr && val_r >= MAX_VAL |=> val_r == 8'h00)
        else $error("out of range value did not wrap");
endmodule

// ### rtcs_cnt_if.sv
// link between the bus slave and one bcd time counter
`timescale 1ns/1ps
interface rtcs_cnt_if;
    logic inc;
    logic wr;
    logic carry;
    logic [7:0] wdata;
    logic [7:0] value;
    modport ctl(output inc, output wr, output wdata, input value, input carry);
    modport cnt(input inc, input wr, input wdata, output value, output carry);
endinterface

// ### rtcs_defs.svh
// constants for the clock chip serial slave and its time counters
`ifndef RTCS_DEFS_SVH
`define RTCS_DEFS_SVH
`define RTCS_DEV_ADDR 7'h32
`define RTCS_SEC_IDX 8'h00
`define RTCS_MIN_IDX 8'h01
`define RTCS_HOUR_IDX 8'h02
`define RTCS_SEC_MAX 8'h59
`define RTCS_MIN_MAX 8'h59
`define RTCS_HOUR_MAX 8'h23
`define RTCS_BCD_DIGIT_MAX 4'h9
`define RTCS_VAL_RST 8'h00
`define RTCS_RCV_PULSES 4'h9
`define RTCS_WD_MAX 2'h2
`define RTCS_LAST_BIT 3'h7
`endif

// ### rtcs_master_model.sv
// bus master model that drives the clock chip serial slave
`timescale 1ns/1ps
module rtcs_master_model (
    input wire logic clock,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    localparam int HALF = 6;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge clock);
    endtask
    // sda moves a cycle after scl falls so no false stop is seen
    task automatic bit_io(input logic b, output logic r);
        wait_n(1);
        sda_low = ~b;
        wait_n(HALF);
        scl = 1'b1;
        wait_n(HALF);
        r = sda;
        scl = 1'b0;
    endtask
    // also serves as repeated start; the slave has released by then
    task automatic start();
        wait_n(1);
        sda_low = 1'b0;
        wait_n(HALF);
        scl = 1'b1;
        wait_n(HALF);
        sda_low = 1'b1;
        wait_n(HALF);
        scl = 1'b0;
    endtask
    // every transfer ends between ticks except those of t_freeze and t_abort
    task automatic stop();
        wait_n(1);
        sda_low = 1'b1;
        wait_n(HALF);
        scl = 1'b1;
        wait_n(HALF);
        sda_low = 1'b0;
        wait_n(HALF);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack, r);
    endtask
    // nine pulses with sda released, then stop from the caller
    task automatic pulses9();
        logic r;
        repeat (9) bit_io(1'b1, r);
    endtask
endmodule

// ### rtcs_pkg.sv
// types shared by the clock chip serial slave
package rtcs_pkg;
    typedef logic [7:0] rtcs_byte_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ACK, ST_WR, ST_RD, ST_RACK, ST_RLD, ST_IGN
    } rtcs_state_e;
endpackage

// ### rtcs_slave.sv
// serial slave of the clock chip with freeze, watchdog and bus recovery
// Function
// - nine low clocks reset slave, release data
// - all-zero general call address gets no acknowledge
// - acknowledge every received byte when addressed
// - unhandled general call bytes left unacknowledged
// - time registers hold bcd; master writes bcd
// - seconds accept out-of-range writes like 61
// - counting returns invalid value to valid range
// - bus reset clears interface only, not time
// - counters frozen START to STOP of one transaction
// - transaction over one second aborted, second lost
`timescale 1ns/1ps
`include "rtcs_defs.svh"
module rtcs_slave #(
    parameter logic [6:0] DEV_ADDR = `RTCS_DEV_ADDR
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic bus_rst_n_in,
    input wire logic tick_in,
    output logic sda_oe,
    output rtcs_pkg::rtcs_byte_t sec_bcd,
    output rtcs_pkg::rtcs_byte_t min_bcd,
    output rtcs_pkg::rtcs_byte_t hour_bcd,
    output logic frozen
);
    import rtcs_pkg::*;

    // pin synchronisers; stage 1 feeds stage 2 only
    logic [1:0] scl_sy_r, sda_sy_r, rst_sy_r, tck_sy_r;
    logic scl_d_r, sda_d_r, tck_d_r;
    logic scl_s, sda_s;
    logic scl_rise, scl_fall, start_ev, stop_ev, bus_rst_ev, tick_ev;

    always_ff @(posedge clock) begin
        if (srst) begin
            scl_sy_r <= 2'h3;
            sda_sy_r <= 2'h3;
            rst_sy_r <= 2'h3;
            tck_sy_r <= 2'h0;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            tck_d_r <= 1'b0;
        end else begin
            scl_sy_r <= {scl_sy_r[0], scl_in};
            sda_sy_r <= {sda_sy_r[0], sda_in};
            rst_sy_r <= {rst_sy_r[0], bus_rst_n_in};
            tck_sy_r <= {tck_sy_r[0], tick_in};
            scl_d_r <= scl_sy_r[1];
            sda_d_r <= sda_sy_r[1];
            tck_d_r <= tck_sy_r[1];
        end
    end

    assign scl_s = scl_sy_r[1];
    assign sda_s = sda_sy_r[1];
    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    assign start_ev = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop_ev = scl_s && scl_d_r && !sda_d_r && sda_s;
    assign bus_rst_ev = !rst_sy_r[1];
    assign tick_ev = tck_sy_r[1] && !tck_d_r;

    // protocol state
    rtcs_state_e st_r, st_nxt;
    rtcs_byte_t sh_r, sh_nxt, ptr_r, ptr_nxt, rx_byte, rd_data;
    logic [2:0] bc_r, bc_nxt;
    logic [3:0] rcv_r, rcv_nxt;
    logic rw_r, rw_nxt, first_r, first_nxt, oe_r, oe_nxt;
    logic wr_en, rcv_hit, abort;
    logic blk_r, blk_nxt, inc_r, inc_nxt;
    logic [1:0] wd_r, wd_nxt;

    rtcs_cnt_if sec_if();
    rtcs_cnt_if min_if();
    rtcs_cnt_if hour_if();

    assign rx_byte = {sh_r[6:0], sda_s};
    // our own drive does not count: a written 00 byte plus our ack must not trip it
    assign rcv_hit = scl_rise && !sda_s && !oe_r
        && rcv_r == `RTCS_RCV_PULSES - 4'h1;
    assign abort = blk_r && tick_ev && wd_r == `RTCS_WD_MAX - 2'h1;
    always_comb begin
        unique case (ptr_r)
            `RTCS_SEC_IDX: rd_data = sec_if.value;
            `RTCS_MIN_IDX: rd_data = min_if.value;
            `RTCS_HOUR_IDX: rd_data = hour_if.value;
            default: rd_data = 8'h00;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        sh_nxt = sh_r;
        bc_nxt = bc_r;
        rw_nxt = rw_r;
        ptr_nxt = ptr_r;
        first_nxt = first_r;
        oe_nxt = oe_r;
        rcv_nxt = rcv_r;
        wr_en = 1'b0;
        if (scl_rise) begin
            rcv_nxt = (sda_s || oe_r) ? 4'h0 : rcv_r + 4'h1;
        end
        if (start_ev || stop_ev || rcv_hit) begin
            rcv_nxt = 4'h0;
        end
        if (bus_rst_ev || abort || stop_ev || rcv_hit) begin
            st_nxt = ST_IDLE; // only a new START leaves idle
            oe_nxt = 1'b0;
        end else if (start_ev) begin
            st_nxt = ST_ADDR;
            bc_nxt = 3'h0;
            first_nxt = 1'b1;
            oe_nxt = 1'b0;
        end else begin
            unique case (st_r)
                ST_IDLE, ST_IGN: begin
                    oe_nxt = 1'b0; // general call and foreign bytes stay silent
                end
                ST_ADDR: if (scl_rise) begin
                    sh_nxt = rx_byte;
                    bc_nxt = bc_r + 3'h1;
                    if (bc_r == `RTCS_LAST_BIT) begin
                        rw_nxt = rx_byte[0];
                        // address 00 never matches a nonzero own address
                        st_nxt = (rx_byte[7:1] == DEV_ADDR && DEV_ADDR != 7'h00)
                            ? ST_ACK : ST_IGN;
                    end
                end
                ST_WR: if (scl_rise) begin
                    sh_nxt = rx_byte;
                    bc_nxt = bc_r + 3'h1;
                    if (bc_r == `RTCS_LAST_BIT) begin
                        st_nxt = ST_ACK;
                        first_nxt = 1'b0;
                        if (first_r) begin
                            ptr_nxt = rx_byte;
                        end else begin
                            wr_en = 1'b1;
                            ptr_nxt = ptr_r + 8'h01;
                        end
                    end
                end
                ST_ACK: if (scl_fall) begin
                    bc_nxt = 3'h0;
                    if (!oe_r) begin
                        oe_nxt = 1'b1; // ack slot pulled low
                    end else if (rw_r) begin
                        sh_nxt = rd_data;
                        oe_nxt = !rd_data[7];
                        st_nxt = ST_RD;
                    end else begin
                        oe_nxt = 1'b0;
                        st_nxt = ST_WR;
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        sh_nxt = {sh_r[6:0], 1'b0};
                        oe_nxt = !sh_r[6];
                    end
                    if (scl_rise) begin
                        bc_nxt = bc_r + 3'h1;
                        if (bc_r == `RTCS_LAST_BIT) begin
                            st_nxt = ST_RACK;
                            ptr_nxt = ptr_r + 8'h01;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_fall) begin
                        oe_nxt = 1'b0;
                    end
                    if (scl_rise) begin
                        st_nxt = sda_s ? ST_IGN : ST_RLD;
                    end
                end
                ST_RLD: if (scl_fall) begin
                    sh_nxt = rd_data;
                    oe_nxt = !rd_data[7];
                    bc_nxt = 3'h0;
                    st_nxt = ST_RD;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_r <= ST_IDLE;
            sh_r <= 8'h00;
            bc_r <= 3'h0;
            rw_r <= 1'b0;
            ptr_r <= 8'h00;
            first_r <= 1'b1;
            oe_r <= 1'b0;
            rcv_r <= 4'h0;
        end else begin
            st_r <= st_nxt;
            sh_r <= sh_nxt;
            bc_r <= bc_nxt;
            rw_r <= rw_nxt;
            ptr_r <= ptr_nxt;
            first_r <= first_nxt;
            oe_r <= oe_nxt;
            rcv_r <= rcv_nxt;
        end
    end

    // freeze and watchdog; bus reset never touches the counters
    always_comb begin
        blk_nxt = blk_r;
        wd_nxt = wd_r;
        inc_nxt = 1'b0;
        if (abort) begin
            blk_nxt = 1'b0; // two ticks missed, one repaid: a second is lost
            wd_nxt = 2'h0;
            inc_nxt = 1'b1;
        end else if (blk_r) begin
            if (tick_ev) begin
                wd_nxt = wd_r + 2'h1; // tick held back while frozen
            end
            if (stop_ev || bus_rst_ev || rcv_hit) begin
                blk_nxt = 1'b0;
            end
        end else begin
            blk_nxt = start_ev; // freeze spans one START..STOP only
            if (wd_r != 2'h0) begin
                inc_nxt = 1'b1;
                wd_nxt = tick_ev ? wd_r : wd_r - 2'h1;
            end else begin
                inc_nxt = tick_ev;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            blk_r <= 1'b0;
            wd_r <= 2'h0;
            inc_r <= 1'b0;
        end else begin
            blk_r <= blk_nxt;
            wd_r <= wd_nxt;
            inc_r <= inc_nxt;
        end
    end
    assign sec_if.inc = inc_r;
    assign min_if.inc = sec_if.carry;
    assign hour_if.inc = min_if.carry;
    assign sec_if.wr = wr_en && ptr_r == `RTCS_SEC_IDX;
    assign min_if.wr = wr_en && ptr_r == `RTCS_MIN_IDX;
    assign hour_if.wr = wr_en && ptr_r == `RTCS_HOUR_IDX;
    assign sec_if.wdata = rx_byte;
    assign min_if.wdata = rx_byte;
    assign hour_if.wdata = rx_byte;
    rtcs_bcd_cnt #(.MAX_VAL(`RTCS_SEC_MAX)) u_sec (.clock(clock), .srst(srst), .c(sec_if));
    rtcs_bcd_cnt #(.MAX_VAL(`RTCS_MIN_MAX)) u_min (.clock(clock), .srst(srst), .c(min_if));
    rtcs_bcd_cnt #(.MAX_VAL(`RTCS_HOUR_MAX)) u_hour (.clock(clock), .srst(srst), .c(hour_if));
    assign sda_oe = oe_r;
    assign sec_bcd = sec_if.value;
    assign min_bcd = min_if.value;
    assign hour_bcd = hour_if.value;
    assign frozen = blk_r;
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    chk_rcv_release: assert property (rcv_hit |=> st_r == ST_IDLE && !oe_r)
        else $error("recovery did not release the bus");
    chk_gc_ignored: assert property (st_r == ST_ADDR && scl_rise && bc_r == 3'h7
        && rx_byte[7:1] == 7'h00 && !stop_ev && !bus_rst_ev && !abort && !rcv_hit
        |=> st_r == ST_IGN) else $error("general call not ignored");
    chk_ign_quiet: assert property (st_r == ST_IGN |-> !oe_r)
        else $error("data driven while ignoring");
    chk_ack_drive: assert property (st_r == ST_ACK && scl_fall && !oe_r
        && !stop_ev && !start_ev && !bus_rst_ev && !abort |=> oe_r)
        else $error("ack not driven");
    chk_freeze_hold: assert property (blk_r && !abort |=> !inc_r)
        else $error("counters advanced while frozen");
    chk_abort_once: assert property (abort |=> !blk_r && inc_r && st_r == ST_IDLE
        ##1 !inc_r) else $error("watchdog abort wrong");
    chk_bus_reset: assert property (bus_rst_ev && !blk_r && wd_r == 2'h0 && !tick_ev
        |=> st_r == ST_IDLE && $stable(sec_bcd)) else $error("bus reset touched time");
    chk_stop_idle: assert property (stop_ev |=> st_r == ST_IDLE ##1 st_r == ST_IDLE)
        else $error("stop did not return to idle");
    cov_gen_call: cover property (st_r == ST_ADDR && scl_rise && bc_r == 3'h7
        && rx_byte == 8'h00);
    cov_abort: cover property (abort);
    cov_read_byte: cover property (st_r == ST_RD ##[1:400] st_r == ST_RACK);
    cov_recovery: cover property (rcv_hit);
endmodule
